// ==== rtl/mpg_pkg.sv ====
// package: register map, field positions and reset values of the gating stage
package mpg_pkg;
  // axi4-lite register byte addresses
  localparam logic [3:0] MPG_ADDR_CTRL   = 4'h0;  // control word
  localparam logic [3:0] MPG_ADDR_STATUS = 4'h4;  // live state, read only
  localparam logic [3:0] MPG_ADDR_EVENT  = 4'h8;  // sticky events, w1c
  // control fields
  localparam int MPG_CTRL_EN_BIT = 0;             // software drive enable
  localparam logic [31:0] MPG_CTRL_RESET = 32'h0000_0001;
  // status fields
  localparam int MPG_ST_MOD_BIT   = 0;            // modulation latch
  localparam int MPG_ST_SENSE_BIT = 1;            // current sense latch
  localparam int MPG_ST_FAULT_BIT = 2;            // fault condition active
  localparam int MPG_ST_UV_BIT    = 3;            // any undervoltage
  localparam int MPG_ST_HOT_BIT   = 4;            // thermal shutdown
  localparam int MPG_ST_BADS_BIT  = 5;            // invalid sensor code
  localparam int MPG_ST_FPIN_BIT  = 6;            // fault pin level
  localparam int MPG_ST_TPIN_LSB  = 7;            // top pin levels, 3 bits
  localparam int MPG_ST_BOT_LSB   = 10;           // bottom drives, 3 bits
  // sticky event fields
  localparam int MPG_EV_OC_BIT   = 0;             // overcurrent seen
  localparam int MPG_EV_UV_BIT   = 1;             // undervoltage seen
  localparam int MPG_EV_HOT_BIT  = 2;             // thermal shutdown seen
  localparam int MPG_EV_BADS_BIT = 3;             // invalid sensor seen
  localparam int MPG_EV_WIDTH    = 4;
  localparam logic [MPG_EV_WIDTH-1:0] MPG_EV_RESET = 4'h0;
  // axi response codes
  localparam logic [1:0] MPG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MPG_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/mpg_latch_pair.sv ====
// the dual latch pair that allows one conduction pulse per ramp cycle
`timescale 1ns/1ns
`default_nettype none
module mpg_latch_pair
  import mpg_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic cycle_start,   // ramp discharge, start of cycle
  input  wire logic speed_trip,    // ramp above speed command
  input  wire logic overcurrent,   // sense above threshold
  output logic      mod_next,      // next modulation latch value
  output logic      sense_next,    // next current sense latch value
  output logic      mod_q,         // modulation latch
  output logic      sense_q        // current sense latch
);
  logic mod_reg;                   // upper latch
  logic sense_reg;                 // lower latch

  // next values: only the cycle start sets, comparators clear
  always_comb begin
    mod_next   = mod_reg;
    sense_next = sense_reg;
    if (cycle_start) begin
      mod_next   = 1'b1;           // [R1]
      sense_next = 1'b1;           // [R1]
    end else begin
      if (speed_trip) begin
        mod_next = 1'b0;           // [R2]
      end
      if (overcurrent) begin
        sense_next = 1'b0;         // [R4]
      end
    end
  end

  // register the latches
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mod_reg   <= 1'b0;
      sense_reg <= 1'b0;
    end else begin
      mod_reg   <= mod_next;
      sense_reg <= sense_next;
    end
  end

  assign mod_q   = mod_reg;
  assign sense_q = sense_reg;

  // a cleared latch stays clear until the next cycle start
  sequence s_cleared_no_start;
    !mod_reg && !cycle_start;
  endsequence
  property p_no_retrigger;
    @(posedge sys_clk) disable iff (rst)
      s_cleared_no_start |=> !mod_reg;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) // [R5]
    else $error("modulation latch set without cycle start");

  property p_oc_clears;
    @(posedge sys_clk) disable iff (rst)
      (overcurrent && !cycle_start) |=> !sense_reg;
  endproperty
  a_oc_clears: assert property (p_oc_clears) // [R4]
    else $error("sense latch not cleared by overcurrent");
endmodule
`default_nettype wire

// ==== rtl/mpg_top.sv ====
// motor pwm and protection gating stage with axi4-lite registers
//
// Notes on behaviour
// [R1] cycle start sets both latches
// [R2] speed comparator clears the modulation latch
// [R3] chopping applies to bottom drives only
// [R4] overcurrent clears sense latch, drive off
// [R5] at most one conduction pulse per cycle
// [R6] fault low on any protection condition
// [R7] undervoltage: fault, tops off, bottoms low
// [R8] thermal shutdown acts as enable low
// [R9] system may latch shutdown via delayed feedback
// [R10] fault and top drives are active low
// [R11] enable low: tops off, bottoms follow brake
// [R12] bottoms need selection and both latches
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mpg_top
  import mpg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // comparators and monitors
  input  wire logic        cycle_start,
  input  wire logic        speed_trip,
  input  wire logic        overcurrent,
  input  wire logic        uv_logic_supply,
  input  wire logic        uv_bottom_supply,
  input  wire logic        uv_reference,
  input  wire logic        thermal_shutdown,
  input  wire logic        output_enable,
  input  wire logic        brake,
  // commutation decode
  input  wire logic        sensor_valid,
  input  wire logic [2:0]  comm_top,
  input  wire logic [2:0]  comm_bottom,
  // drive pins
  input  wire logic [2:0]  top_drive_n_i,
  output logic      [2:0]  top_drive_n_o,
  output logic      [2:0]  top_drive_n_oe,
  output logic      [2:0]  bottom_drive,
  input  wire logic        fault_n_i,
  output logic             fault_n_o,
  output logic             fault_n_oe,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic                    mod_next;      // latch next values
  logic                    sense_next;
  logic                    mod_q;         // latch states
  logic                    sense_q;
  logic                    uv_any;        // any undervoltage monitor
  logic                    drive_en;      // enable after thermal and sw
  logic                    fault_cond;    // fault condition
  logic [2:0]              top_on;        // top switch conducts
  logic [2:0]              bot_on;        // bottom drive level
  logic [2:0]              top_oe_reg;
  logic [2:0]              top_oe_next;
  logic [2:0]              bot_reg;
  logic [2:0]              bot_next;
  logic                    fault_oe_reg;
  logic                    fault_oe_next;
  logic [31:0]             ctrl_reg;
  logic [31:0]             ctrl_next;
  logic [MPG_EV_WIDTH-1:0] ev_reg;
  logic [MPG_EV_WIDTH-1:0] ev_next;
  logic [MPG_EV_WIDTH-1:0] ev_set;
  logic [MPG_EV_WIDTH-1:0] ev_clr;
  logic                    bvalid_reg;
  logic                    bvalid_next;
  logic [1:0]              bresp_reg;
  logic [1:0]              bresp_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic [1:0]              rresp_reg;
  logic [1:0]              rresp_next;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic                    wr_fire;       // write taken this cycle
  logic                    rd_fire;       // read taken this cycle
  logic [31:0]             status_word;

  // address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == MPG_ADDR_CTRL) || (a == MPG_ADDR_STATUS) ||
                  (a == MPG_ADDR_EVENT);
  endfunction

  // dual latch pwm core
  mpg_latch_pair u_latch (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .cycle_start (cycle_start),
    .speed_trip  (speed_trip),
    .overcurrent (overcurrent),
    .mod_next    (mod_next),
    .sense_next  (sense_next),
    .mod_q       (mod_q),
    .sense_q     (sense_q)
  );

  // protection and drive selection, priority from uv downward
  always_comb begin
    uv_any     = uv_logic_supply | uv_bottom_supply | uv_reference;
    drive_en   = output_enable & ~thermal_shutdown      // [R8]
                 & ctrl_reg[MPG_CTRL_EN_BIT];
    fault_cond = ~sensor_valid | ~output_enable | overcurrent
                 | uv_any | thermal_shutdown;           // [R6]
    top_on     = 3'h0;
    bot_on     = 3'h0;
    if (uv_any) begin
      bot_on = 3'h0;                                    // [R7]
    end else if (!sensor_valid || !drive_en) begin
      bot_on = {3{brake}};                              // [R11]
    end else if (brake) begin
      bot_on = 3'h7;
    end else begin
      top_on = comm_top;                                // [R3]
      bot_on = comm_bottom & {3{mod_next & sense_next}}; // [R12]
    end
  end

  // drive output next values; open collector pulls low when on
  always_comb begin
    top_oe_next   = top_on;                             // [R10]
    bot_next      = bot_on;
    fault_oe_next = fault_cond;                         // [R10]
  end

  // drive output registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      top_oe_reg   <= 3'h0;
      bot_reg      <= 3'h0;
      fault_oe_reg <= 1'b0;
    end else begin
      top_oe_reg   <= top_oe_next;
      bot_reg      <= bot_next;
      fault_oe_reg <= fault_oe_next;
    end
  end

  assign top_drive_n_o  = 3'h0;
  assign top_drive_n_oe = top_oe_reg;
  assign bottom_drive   = bot_reg;
  assign fault_n_o      = 1'b0;
  assign fault_n_oe     = fault_oe_reg;

  // live status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[MPG_ST_MOD_BIT]   = mod_q;
    status_word[MPG_ST_SENSE_BIT] = sense_q;
    status_word[MPG_ST_FAULT_BIT] = fault_oe_reg;
    status_word[MPG_ST_UV_BIT]    = uv_any;
    status_word[MPG_ST_HOT_BIT]   = thermal_shutdown;
    status_word[MPG_ST_BADS_BIT]  = ~sensor_valid;
    status_word[MPG_ST_FPIN_BIT]  = fault_n_i;
    status_word[MPG_ST_TPIN_LSB +: 3] = top_drive_n_i;
    status_word[MPG_ST_BOT_LSB +: 3]  = bot_reg;
  end

  // bus slave next values: write takes address and data together
  always_comb begin
    wr_fire     = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    rd_fire     = s_axi_arvalid & ~rvalid_reg;
    ctrl_next   = ctrl_reg;
    ev_clr      = '0;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    ev_set      = '0;
    ev_set[MPG_EV_OC_BIT]   = overcurrent;
    ev_set[MPG_EV_UV_BIT]   = uv_any;
    ev_set[MPG_EV_HOT_BIT]  = thermal_shutdown;
    ev_set[MPG_EV_BADS_BIT] = ~sensor_valid;
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next  = addr_mapped(s_axi_awaddr) ? MPG_RESP_OKAY
                                              : MPG_RESP_SLVERR;
      if (s_axi_awaddr == MPG_ADDR_CTRL && s_axi_wstrb[0]) begin
        ctrl_next[7:0] = s_axi_wdata[7:0];
      end
      if (s_axi_awaddr == MPG_ADDR_EVENT && s_axi_wstrb[0]) begin
        ev_clr = s_axi_wdata[MPG_EV_WIDTH-1:0];
      end
    end
    // a new event in the clearing cycle survives the clear
    ev_next = (ev_reg & ~ev_clr) | ev_set;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = addr_mapped(s_axi_araddr) ? MPG_RESP_OKAY
                                              : MPG_RESP_SLVERR;
      unique case (s_axi_araddr)
        MPG_ADDR_CTRL:   rdata_next = ctrl_reg;
        MPG_ADDR_STATUS: rdata_next = status_word;
        MPG_ADDR_EVENT:  rdata_next = {28'h0, ev_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // bus slave registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg   <= MPG_CTRL_RESET;
      ev_reg     <= MPG_EV_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg  <= MPG_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= MPG_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      ev_reg     <= ev_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign s_axi_awready = s_axi_wvalid & ~bvalid_reg;
  assign s_axi_wready  = s_axi_awvalid & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // checks on the drive stage
  sequence s_cycle_start;
    cycle_start && !rst;
  endsequence
  property p_start_sets;
    @(posedge sys_clk) disable iff (rst)
      s_cycle_start |=> (mod_q && sense_q);
  endproperty
  a_start_sets: assert property (p_start_sets) // [R1]
    else $error("cycle start did not set both latches");

  property p_speed_ends;
    @(posedge sys_clk) disable iff (rst)
      (speed_trip && !cycle_start) |=>
        (bottom_drive == 3'h0 || $past(brake));
  endproperty
  a_speed_ends: assert property (p_speed_ends) // [R2]
    else $error("bottom drive survived speed trip");

  property p_top_not_chopped;
    @(posedge sys_clk) disable iff (rst)
      (speed_trip && sensor_valid && drive_en && !brake && !uv_any)
        |=> (top_drive_n_oe == $past(comm_top));
  endproperty
  a_top_not_chopped: assert property (p_top_not_chopped) // [R3]
    else $error("top drive chopped by modulation");

  property p_fault;
    @(posedge sys_clk) disable iff (rst)
      fault_cond |=> fault_n_oe;
  endproperty
  a_fault: assert property (p_fault) // [R6]
    else $error("fault pin not pulled low");

  property p_uv;
    @(posedge sys_clk) disable iff (rst)
      uv_any |=> (top_drive_n_oe == 3'h0 && bottom_drive == 3'h0
                  && fault_n_oe);
  endproperty
  a_uv: assert property (p_uv) // [R7]
    else $error("undervoltage did not shut drives");

  property p_thermal;
    @(posedge sys_clk) disable iff (rst)
      (thermal_shutdown && !uv_any) |=>
        (top_drive_n_oe == 3'h0 && bottom_drive == {3{$past(brake)}});
  endproperty
  a_thermal: assert property (p_thermal) // [R8]
    else $error("thermal shutdown differs from enable low");

  property p_enable_low;
    @(posedge sys_clk) disable iff (rst)
      (!output_enable && sensor_valid && !uv_any) |=>
        (top_drive_n_oe == 3'h0 && bottom_drive == {3{$past(brake)}}
         && fault_n_oe);
  endproperty
  a_enable_low: assert property (p_enable_low) // [R11]
    else $error("enable low drive pattern wrong");

  property p_bottom_gated;
    @(posedge sys_clk) disable iff (rst)
      (!brake && sensor_valid && drive_en && !uv_any) |=>
        (bottom_drive == ($past(comm_bottom)
                          & {3{mod_q & sense_q}}));
  endproperty
  a_bottom_gated: assert property (p_bottom_gated) // [R12]
    else $error("bottom drive not gated by latches");
endmodule
`default_nettype wire

// ==== tb/mpg_bridge_model.sv ====
// power bridge side: open-collector pull-ups and delayed shutdown feedback
`timescale 1ns/1ns
`default_nettype none
module mpg_bridge_model #(
  parameter int DLY = 16                  // delay element charge time, cycles
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] top_drive_n_oe, // device pulls top pins low
  input  wire logic [2:0] bottom_drive,   // bottom gate drives
  input  wire logic       fault_n_oe,     // device pulls fault pin low
  input  wire logic       discharge,      // shorts the delay element
  output logic      [2:0] top_pin_n,      // resolved top pin levels
  output logic            fault_pin_n,    // resolved fault pin level
  output logic            enable_fb       // feedback into output enable
);
  int   cnt;                              // delay element charge level
  logic shut;                             // shutdown latched by feedback
  // pull-ups: a pin is low only while the device sinks it
  assign top_pin_n   = ~top_drive_n_oe;
  assign fault_pin_n = ~fault_n_oe;
  assign enable_fb   = ~shut;
  // delay element charges while fault stays low, then latches enable low
  always_ff @(posedge sys_clk) begin
    if (rst || discharge) begin
      cnt  <= 0;
      shut <= 1'b0;
    end else if (!fault_pin_n) begin
      if (cnt >= DLY) shut <= 1'b1;
      else cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the pwm and protection gating stage
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mpg_pkg::*;
  logic        sys_clk, rst, cycle_start, speed_trip, overcurrent;
  logic        uv_logic_supply, uv_bottom_supply, uv_reference;
  logic        thermal_shutdown, oe_drv, brake, sensor_valid, discharge;
  logic [2:0]  comm_top, comm_bottom, top_drive_n_o, top_drive_n_oe;
  logic [2:0]  bottom_drive, top_pin_n;
  logic        fault_n_o, fault_n_oe, fault_pin_n, enable_fb;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, seed;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  logic        mod_m, sense_m, ctrl_en_m, run_chk, fault_e;
  logic [2:0]  bot_e, top_e;
  int          n_mismatch, checks;
  wire logic   output_enable = oe_drv & enable_fb;  // feedback loop
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  mpg_top i_mpg_top (.sys_clk, .rst, .cycle_start, .speed_trip, .overcurrent,
    .uv_logic_supply, .uv_bottom_supply, .uv_reference, .thermal_shutdown,
    .output_enable, .brake, .sensor_valid, .comm_top, .comm_bottom,
    .top_drive_n_i(top_pin_n), .top_drive_n_o, .top_drive_n_oe, .bottom_drive,
    .fault_n_i(fault_pin_n), .fault_n_o, .fault_n_oe, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  mpg_bridge_model #(.DLY(16)) i_mpg_bridge_model (.sys_clk, .rst,
    .top_drive_n_oe, .bottom_drive, .fault_n_oe, .discharge, .top_pin_n,
    .fault_pin_n, .enable_fb);
  // reference model of the drive stage, sampled like the design
  always @(posedge sys_clk) begin
    logic uv, en, mn, sn;
    uv = uv_logic_supply | uv_bottom_supply | uv_reference;
    en = output_enable & ~thermal_shutdown & ctrl_en_m;
    mn = cycle_start | (mod_m & ~speed_trip);
    sn = cycle_start | (sense_m & ~overcurrent);
    if (rst) {mn, sn, top_e, bot_e} = 8'h00;
    else if (uv) {top_e, bot_e} = 6'h00;
    else if (!sensor_valid || !en)
      {top_e, bot_e} = {3'h0, {3{brake}}};
    else if (brake) {top_e, bot_e} = {3'h0, 3'h7};
    else {top_e, bot_e} = {comm_top, comm_bottom & {3{mn & sn}}};
    fault_e = !rst & (~sensor_valid | ~output_enable | overcurrent | uv
              | thermal_shutdown);
    mod_m = mn;
    sense_m = sn;
  end
  // compare outputs once they have settled
  always @(negedge sys_clk) begin
    if (run_chk) begin
      chk({29'h0, bottom_drive}, {29'h0, bot_e});
      chk({29'h0, top_drive_n_oe}, {29'h0, top_e});
      chk({31'h0, fault_n_oe}, {31'h0, fault_e});
      chk({29'h0, top_drive_n_o}, 32'h0);
      chk({31'h0, fault_n_o}, 32'h0);
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (!(awready && wready) && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (!bvalid && n < 100);
    rs = bresp;
    if (n >= 100) begin n_mismatch++; final_report(); end
  endtask
  // one read, response taken at the handshake edge
  task automatic axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge sys_clk); n++; end while (!rvalid && n < 100);
    rd = rdata;
    rs = rresp;
    if (n >= 100) begin n_mismatch++; final_report(); end
  endtask
  // quiet, valid, enabled inputs held for n cycles
  task automatic quiet(input int n);
    {cycle_start, speed_trip, overcurrent, uv_reference, brake} <= 5'h00;
    {uv_logic_supply, uv_bottom_supply, thermal_shutdown} <= 3'h0;
    {oe_drv, sensor_valid, discharge} <= 3'h7;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic set_ctrl(input logic en);
    run_chk = 1'b0;
    axi_wr(MPG_ADDR_CTRL, {31'h0, en});
    ctrl_en_m = en;
    repeat (2) @(posedge sys_clk);
    run_chk = 1'b1;
  endtask
  task automatic rand_run(input int n);
    repeat (n) begin
      seed = xs(seed);
      cycle_start <= seed[2:0] == 3'h0;
      speed_trip <= seed[5:3] == 3'h0;
      overcurrent <= seed[9:6] == 4'h0;
      uv_logic_supply <= seed[14:10] == 5'h00;
      uv_bottom_supply <= seed[19:15] == 5'h00;
      uv_reference <= seed[24:20] == 5'h00;
      thermal_shutdown <= seed[29:25] == 5'h00;
      oe_drv <= seed[30] | seed[31];
      seed = xs(seed);
      brake <= seed[1:0] == 2'h0;
      sensor_valid <= seed[4:2] != 3'h0;
      discharge <= seed[8:5] == 4'h0;
      comm_top <= seed[11:9];
      comm_bottom <= seed[14:12];
      @(posedge sys_clk);
    end
  endtask
  initial begin
    logic [4:0] cs [6];
    cs = '{5'h06, 5'h16, 5'h0E, 5'h02, 5'h05, 5'h07};
    {rst, oe_drv, sensor_valid, ctrl_en_m, run_chk} = 5'h1F;
    {cycle_start, speed_trip, overcurrent, uv_logic_supply} = 4'h0;
    {uv_bottom_supply, uv_reference, thermal_shutdown, brake} = 4'h0;
    {discharge, comm_top, comm_bottom} = 7'h00;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'h3;  // responses are always accepted
    seed = 32'h0000AD1B;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    axi_rd(MPG_ADDR_CTRL);
    chk(rd, MPG_CTRL_RESET);
    chk({30'h0, rs}, {30'h0, MPG_RESP_OKAY});
    axi_rd(MPG_ADDR_EVENT);
    chk(rd, {28'h0, MPG_EV_RESET});
    axi_rd(4'hC);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, MPG_RESP_SLVERR});
    axi_wr(4'hC, 32'h0000_00FF);
    chk({30'h0, rs}, {30'h0, MPG_RESP_SLVERR});
    $display("register reset and decode test done");
    rand_run(1500);
    set_ctrl(1'b0);
    rand_run(500);
    set_ctrl(1'b1);
    $display("random drive test done");
    foreach (cs[i]) begin
      quiet(1);
      {uv_reference, thermal_shutdown, sensor_valid, oe_drv, brake} <= cs[i];
      comm_top <= 3'h1;
      comm_bottom <= 3'h4;
      cycle_start <= 1'b1;
      @(posedge sys_clk);
      cycle_start <= 1'b0;
      repeat (3) @(posedge sys_clk);
      axi_rd(MPG_ADDR_STATUS);
      chk(rd, {19'h0, bot_e, ~top_e, ~fault_e, ~sensor_valid, thermal_shutdown,
               uv_reference, fault_e, sense_m, mod_m});
    end
    $display("status test done");
    quiet(2);
    axi_wr(MPG_ADDR_EVENT, 32'h0000_000F);
    axi_rd(MPG_ADDR_EVENT);
    chk(rd, 32'h0);
    overcurrent <= 1'b1;
    uv_reference <= 1'b1;
    @(posedge sys_clk);
    quiet(3);
    axi_rd(MPG_ADDR_EVENT);
    chk(rd, 32'h0000_0003);
    axi_wr(MPG_ADDR_EVENT, 32'h0000_0001);
    axi_rd(MPG_ADDR_EVENT);
    chk(rd, 32'h0000_0002);
    $display("event test done");
    discharge <= 1'b0;
    overcurrent <= 1'b1;
    repeat (30) @(posedge sys_clk);
    overcurrent <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({31'h0, enable_fb}, 32'h0);
    discharge <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({31'h0, fault_n_oe}, 32'h0);
    $display("latched shutdown test done");
    final_report();
  end
endmodule
`default_nettype wire
